// ---- include/cmpirq_pkg.sv ----
// Package for the comparator control block: register map, field layout,
// reset values, encodings and timing constants.
// Assumes a 32-bit APB with one register per aligned word.

package cmpirq_pkg;

	// ****************************************************************
	// Register indices and address width
	// ****************************************************************
	localparam logic [3:0] CTRL_IDX   = 4'h0;
	localparam logic [3:0] MUX_IDX    = 4'h2;
	localparam logic [3:0] DIVREF_IDX = 4'h4;
	localparam logic [3:0] IRQEN_IDX  = 4'h6;
	localparam logic [3:0] STATUS_IDX = 4'h7;
	localparam logic [3:0] SLEEP_IDX  = 4'h8;
	localparam int unsigned ADDR_W    = 6;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned CTRL_EN_B     = 0;
	localparam int unsigned CTRL_HYS_B    = 1;
	localparam int unsigned CTRL_LP_B     = 3;
	localparam int unsigned CTRL_EDGE_B   = 4;
	localparam int unsigned CTRL_PIN_B    = 6;
	localparam int unsigned CTRL_RSTBY_B  = 7;
	localparam int unsigned MUX_NEG_B     = 0;
	localparam int unsigned MUX_POS_B     = 3;
	localparam int unsigned MUX_INV_B     = 7;
	localparam int unsigned ST_FLAG_B     = 0;
	localparam int unsigned ST_STATE_B    = 4;
	localparam int unsigned ST_VALID_B    = 5;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] MUX_RST    = 8'h00;
	localparam logic [7:0] DIVREF_RST = 8'hff;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		EDGE_BOTH    = 2'h0,
		EDGE_RSVD    = 2'h1,
		EDGE_FALLING = 2'h2,
		EDGE_RISING  = 2'h3
	} cmpirq_edge_t;

	typedef enum logic [1:0] {
		SLP_ACTIVE  = 2'h0,
		SLP_IDLE    = 2'h1,
		SLP_STANDBY = 2'h2,
		SLP_PDOWN   = 2'h3
	} cmpirq_sleep_t;

	localparam logic [1:0] NEG_DIVREF = 2'h3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned STARTUP_NS     = 2500;
	localparam int unsigned STARTUP_CYCLES = (STARTUP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SYNC_STAGES    = 3;

endpackage

// ---- include/cmpirq_sync_if.sv ----
// Interface between the control top and its result synchroniser.
// Assumes both ends run on the same peripheral clock.

`timescale 1ns/1ns
`default_nettype none

interface cmpirq_sync_if;
	logic raw;
	logic synced;
	logic rise;
	logic fall;
	modport ctrl (output raw, input synced, input rise, input fall);
	modport sync (input raw, output synced, output rise, output fall);
endinterface

`default_nettype wire

// ---- rtl/cmpirq_sync.sv ----
// Result synchroniser with one-cycle edge pulses taken after the chain.
// Assumes a synchronous active-low reset and a clock enable.

`timescale 1ns/1ns
`default_nettype none

module cmpirq_sync #(
	parameter int unsigned STAGES = cmpirq_pkg::SYNC_STAGES
) (
	// Clock and reset
	input  wire logic      mclk_i,
	input  wire logic      reset_n_i,
	input  wire logic      clk_en_i,
	// Result path
	cmpirq_sync_if.sync    sif
);
	if (STAGES < 2) begin
		$error("cmpirq_sync needs at least two stages");
	end

	typedef struct packed {
		logic [STAGES-1:0] chain;
		logic              prev;
	} cmpirq_sync_state_t;

	cmpirq_sync_state_t st_ff;
	cmpirq_sync_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (clk_en_i) begin
			nxt_st.chain = {st_ff.chain[STAGES-2:0], sif.raw};
			nxt_st.prev  = st_ff.chain[STAGES-1];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Only the last stage is observed; edges compare it with the previous cycle.
	assign sif.synced = st_ff.chain[STAGES-1];
	assign sif.rise   = clk_en_i & st_ff.chain[STAGES-1] & ~st_ff.prev;
	assign sif.fall   = clk_en_i & ~st_ff.chain[STAGES-1] & st_ff.prev;
endmodule

`default_nettype wire

// ---- rtl/cmpirq_top.sv ----
// Digital control around an analog comparator: input selection, result
// shaping, pin drive, level event, edge interrupt and APB registers.
// Assumes the analog core answers with a raw compare bit and that sleep
// state comes from the power controller synchronous to mclk_i.
//
// The APB register port and the address map were left to the implementer.

`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1 - Result is high only when positive input exceeds negative input.
// R2 - Positive mux picks one of four pins; negative one of three or divider.
// R3 - Software configures pins and muxes before setting enable.
// R4 - Result flagged invalid for the start-up time after enabling.
// R5 - Two-bit hysteresis field selects off or three levels.
// R6 - Low-power bit trades current for longer propagation delay.
// R7 - Result goes continuously to software, event and pin together.
// R8 - Interrupt edge is rising, falling or both by selection field.
// R9 - Matching edge sets the flag regardless of interrupt enable.
// R10 - Enable bit one permits the interrupt; zero blocks it.
// R11 - Request asserted while enable and flag set, until flag cleared.
// R12 - Level event follows the result asynchronously, no clock.
// R13 - No event inputs; behaviour depends on registers and analog inputs.
// R14 - Software sets pin direction or pin floats when disabled.
// R15 - Idle sleep behaves exactly like active operation.
// R16 - Standby disables block unless run-in-standby is set.
// R17 - Power-down disables comparator and pin output unconditionally.
// R18 - Edge field: 0 both, 2 falling, 3 rising, 1 reserved.
// R19 - Writing one clears the flag; zero leaves it.
// R20 - State bit follows result through a three-cycle synchroniser.
// R21 - Inversion applies before pin, event, state bit and edge detector.
// R22 - Edge detection compares synchronized result with previous cycle.
module cmpirq_top (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Power controller
	input  wire logic [1:0]  sleep_mode_i,
	// Analog core
	input  wire logic        analog_result_i,                            // R13
	output logic             analog_enable_o,
	output logic [1:0]       positive_input_select_o,
	output logic [1:0]       negative_input_select_o,
	output logic [1:0]       hysteresis_level_o,
	output logic             low_power_select_o,
	output logic [7:0]       internal_reference_divider_o,
	// Result pin, event and interrupt
	output logic             result_pin_o,
	output logic             result_pin_oe_o,
	output logic             result_event_o,
	output logic             irq_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  mux;
		logic [7:0]  divref;
		logic        irq_en;
		logic        flag;
		logic [11:0] startup_cnt;
		logic [31:0] rdata;
	} cmpirq_state_t;

	if (cmpirq_pkg::STARTUP_CYCLES >= 4096) begin
		$error("start-up count overflows its counter");
	end

	cmpirq_state_t st_ff;
	cmpirq_state_t nxt_st;

	cmpirq_sync_if sif ();

	function automatic logic is_reg(input logic [31:0] addr, input logic [3:0] idx);
		is_reg = (addr[cmpirq_pkg::ADDR_W-1:0] == {idx, 2'b00})
			&& (addr[31:cmpirq_pkg::ADDR_W] == '0);
	endfunction

	// ****************************************************************
	// Analog side and result shaping
	// ****************************************************************
	logic         running;
	logic         enabled;
	logic         shaped;
	logic [1:0]   edge_sel;
	logic         edge_hit;
	logic         access;
	logic         wr;
	logic         mapped;
	logic         startup_done;

	assign enabled = st_ff.ctrl[cmpirq_pkg::CTRL_EN_B];

	always_comb begin
		case (cmpirq_pkg::cmpirq_sleep_t'(sleep_mode_i))
			cmpirq_pkg::SLP_ACTIVE:  running = enabled;                    // R15
			cmpirq_pkg::SLP_IDLE:    running = enabled;                    // R15
			cmpirq_pkg::SLP_STANDBY: running = enabled
				& st_ff.ctrl[cmpirq_pkg::CTRL_RSTBY_B];                    // R16
			cmpirq_pkg::SLP_PDOWN:   running = 1'b0;                       // R17
			default:                 running = 1'b0;
		endcase
	end

	// The analog core compares; R3 and R14 are software duties outside here.
	assign analog_enable_o              = running;                        // R1
	assign positive_input_select_o      = st_ff.mux[cmpirq_pkg::MUX_POS_B +: 2];  // R2
	assign negative_input_select_o      = st_ff.mux[cmpirq_pkg::MUX_NEG_B +: 2];  // R2
	assign hysteresis_level_o           = st_ff.ctrl[cmpirq_pkg::CTRL_HYS_B +: 2]; // R5
	assign low_power_select_o           = st_ff.ctrl[cmpirq_pkg::CTRL_LP_B];     // R6
	assign internal_reference_divider_o = st_ff.divref;

	// Result is a pure gate path so the event needs no clock.
	assign shaped          = running & (analog_result_i ^ st_ff.mux[cmpirq_pkg::MUX_INV_B]); // R21
	assign result_event_o  = shaped;                                      // R12 R7
	assign result_pin_o    = shaped;                                      // R7
	assign result_pin_oe_o = running & st_ff.ctrl[cmpirq_pkg::CTRL_PIN_B]; // R17
	assign sif.raw         = shaped;                                      // R20

	assign edge_sel = st_ff.ctrl[cmpirq_pkg::CTRL_EDGE_B +: 2];
	always_comb begin
		case (cmpirq_pkg::cmpirq_edge_t'(edge_sel))
			cmpirq_pkg::EDGE_BOTH:    edge_hit = sif.rise | sif.fall;    // R18 R8
			cmpirq_pkg::EDGE_FALLING: edge_hit = sif.fall;               // R18
			cmpirq_pkg::EDGE_RISING:  edge_hit = sif.rise;               // R18
			default:                  edge_hit = 1'b0;
		endcase
	end

	assign startup_done = (st_ff.startup_cnt == 12'(cmpirq_pkg::STARTUP_CYCLES));
	assign irq_o        = st_ff.irq_en & st_ff.flag;                     // R11

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign access    = psel_i & penable_i;
	assign wr        = access & pwrite_i;
	assign mapped    = is_reg(paddr_i, cmpirq_pkg::CTRL_IDX) | is_reg(paddr_i, cmpirq_pkg::MUX_IDX)
		| is_reg(paddr_i, cmpirq_pkg::DIVREF_IDX) | is_reg(paddr_i, cmpirq_pkg::IRQEN_IDX)
		| is_reg(paddr_i, cmpirq_pkg::STATUS_IDX) | is_reg(paddr_i, cmpirq_pkg::SLEEP_IDX);
	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~mapped;
	assign prdata_o  = st_ff.rdata;

	always_comb begin
		nxt_st = st_ff;
		if (clk_en_i) begin
			// Start-up counter restarts whenever the comparator stops.
			if (!running) begin
				nxt_st.startup_cnt = '0;
			end else if (!startup_done) begin
				nxt_st.startup_cnt = st_ff.startup_cnt + 12'h001;         // R4
			end
			if (wr && is_reg(paddr_i, cmpirq_pkg::CTRL_IDX)) begin
				nxt_st.ctrl = pwdata_i[7:0];
			end
			if (wr && is_reg(paddr_i, cmpirq_pkg::MUX_IDX)) begin
				nxt_st.mux = pwdata_i[7:0] & 8'h9b;
			end
			if (wr && is_reg(paddr_i, cmpirq_pkg::DIVREF_IDX)) begin
				nxt_st.divref = pwdata_i[7:0];
			end
			if (wr && is_reg(paddr_i, cmpirq_pkg::IRQEN_IDX)) begin
				nxt_st.irq_en = pwdata_i[0];                             // R10
			end
			if (wr && is_reg(paddr_i, cmpirq_pkg::STATUS_IDX) && pwdata_i[cmpirq_pkg::ST_FLAG_B]) begin
				nxt_st.flag = 1'b0;                                     // R19
			end
			// Set beats a clear in the same cycle; enable does not gate it.
			if (edge_hit) begin
				nxt_st.flag = 1'b1;                                     // R9 R22
			end
			// Read data is sampled in the setup cycle so it is stable in access.
			nxt_st.rdata = '0;
			if (psel_i && !penable_i && !pwrite_i) begin
				if (is_reg(paddr_i, cmpirq_pkg::CTRL_IDX)) begin
					nxt_st.rdata[7:0] = st_ff.ctrl;
				end else if (is_reg(paddr_i, cmpirq_pkg::MUX_IDX)) begin
					nxt_st.rdata[7:0] = st_ff.mux;
				end else if (is_reg(paddr_i, cmpirq_pkg::DIVREF_IDX)) begin
					nxt_st.rdata[7:0] = st_ff.divref;
				end else if (is_reg(paddr_i, cmpirq_pkg::IRQEN_IDX)) begin
					nxt_st.rdata[0] = st_ff.irq_en;
				end else if (is_reg(paddr_i, cmpirq_pkg::STATUS_IDX)) begin
					nxt_st.rdata[cmpirq_pkg::ST_FLAG_B]  = st_ff.flag;
					nxt_st.rdata[cmpirq_pkg::ST_STATE_B] = sif.synced;      // R20
					nxt_st.rdata[cmpirq_pkg::ST_VALID_B] = startup_done;    // R4
				end else if (is_reg(paddr_i, cmpirq_pkg::SLEEP_IDX)) begin
					nxt_st.rdata[1:0] = sleep_mode_i;
				end else begin
					nxt_st.rdata = '0;
				end
			end else begin
				nxt_st.rdata = st_ff.rdata;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			st_ff.ctrl        <= cmpirq_pkg::CTRL_RST;
			st_ff.mux         <= cmpirq_pkg::MUX_RST;
			st_ff.divref      <= cmpirq_pkg::DIVREF_RST;
			st_ff.irq_en      <= 1'b0;
			st_ff.flag        <= 1'b0;
			st_ff.startup_cnt <= '0;
			st_ff.rdata       <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	cmpirq_sync #(
		.STAGES (cmpirq_pkg::SYNC_STAGES)
	) u_sync (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.sif       (sif.sync)
	);
endmodule

`default_nettype wire

// ---- testbench/cmpirq_analog.sv ----
// Model of the analog side: four positive pins, three negative pins, divider.
// Assumes levels in divider steps, so the divider code is its own level.

`timescale 1ns/1ns
`default_nettype none

module cmpirq_analog (
	// Levels and selections
	input  wire logic [3:0][7:0] pos_lvl_i,
	input  wire logic [2:0][7:0] neg_lvl_i,
	input  wire logic [7:0]      div_i,
	input  wire logic [1:0]      pos_sel_i,
	input  wire logic [1:0]      neg_sel_i,
	input  wire logic            en_i,
	// Raw compare bit
	output logic                 raw_o
);
	logic [7:0] neg_lvl;
	assign neg_lvl = (neg_sel_i == 2'h3) ? div_i : neg_lvl_i[neg_sel_i];
	// A disabled core gives no valid level, so it shows a fixed high level whatever the inputs.
	assign raw_o = en_i ? (pos_lvl_i[pos_sel_i] > neg_lvl) : 1'h1;
endmodule

`default_nettype wire

// ---- testbench/cmpirq_top_chk.sv ----
// Assertion checker for the comparator control top.
// Assumes one clock domain and a synchronous active-low reset.

`timescale 1ns/1ns
`default_nettype none

module cmpirq_chk (
	// Watched ports
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic        clk_en_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [1:0]  sleep_mode_i,
	input wire logic        analog_enable_o,
	input wire logic        result_pin_o,
	input wire logic        result_pin_oe_o,
	input wire logic        result_event_o,
	input wire logic        irq_o
);
	// ****************
	// Write history
	// ****************
	logic [1:0] wr_ff;
	always_ff @(posedge mclk_i) begin
		wr_ff <= reset_n_i ? {wr_ff[0], psel_i & penable_i & pwrite_i & clk_en_i} : 2'h0;
	end
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_acc;
		psel_i && penable_i;
	endsequence
	sequence s_clr;
		s_acc ##0 (pwrite_i && clk_en_i && paddr_i[5:0] == 6'h1c && pwdata_i[0]);
	endsequence
	chk_event_is_pin: assert property (result_event_o == result_pin_o)
		else $error("event differs from pin");
	chk_pdown_quiet: assert property (sleep_mode_i == 2'h3 |-> !analog_enable_o && !result_pin_oe_o)
		else $error("active in power-down");
	chk_off_quiet: assert property (!analog_enable_o |-> !result_pin_o && !result_pin_oe_o)
		else $error("output while disabled");
	chk_ready_now: assert property (s_acc |-> pready_o)
		else $error("no ready in access");
	chk_err_map: assert property (s_acc |-> pslverr_o == !(paddr_i[31:6] == 26'h0 && paddr_i[1:0] == 2'h0
		&& paddr_i[5:2] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8}))
		else $error("wrong error response");
	chk_clear_irq: assert property (s_clr |=> ##[0:1] !irq_o)
		else $error("irq stays after clear");
	chk_irq_fall: assert property ($fell(irq_o) |-> wr_ff != 2'h0)
		else $error("irq fell without write");
	chk_read_hold: assert property (!(psel_i && !penable_i && !pwrite_i && clk_en_i) |=> $stable(prdata_o))
		else $error("read data moved");
	chk_freeze_irq: assert property (!clk_en_i |=> $stable(irq_o))
		else $error("irq moved while frozen");
endmodule

bind cmpirq_top cmpirq_chk u_chk (.*);

`default_nettype wire

// ---- testbench/cmpirq_tb.sv ----
// Self-checking bench for the comparator control top, driven over APB.
// Assumes the analog model stands in for the comparator core.

`timescale 1ns/1ns
`default_nettype none

module cmpirq_tb;
	logic            mclk_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1;
	logic            psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic [31:0]     paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
	logic [1:0]      sleep_mode_i = 2'h0, positive_input_select_o, negative_input_select_o, hysteresis_level_o;
	logic            pready_o, pslverr_o, analog_result_i, analog_enable_o, low_power_select_o, err, exp;
	logic            result_pin_o, result_pin_oe_o, result_event_o, irq_o;
	logic [7:0]      internal_reference_divider_o;
	logic [3:0][7:0] pos_lvl = {8'h82, 8'h5a, 8'h32, 8'h0a};
	logic [2:0][7:0] neg_lvl = {8'h82, 8'h5a, 8'h32};
	int              num_errors = 0, num_checks = 0;

	cmpirq_top dut (.*);
	cmpirq_analog u_ana (
		.pos_lvl_i(pos_lvl), .neg_lvl_i(neg_lvl), .div_i(internal_reference_divider_o),
		.pos_sel_i(positive_input_select_o), .neg_sel_i(negative_input_select_o),
		.en_i(analog_enable_o), .raw_o(analog_result_i)
	);

	initial begin
		forever #20 mclk_i = ~mclk_i;
	end

	// ****************
	// Bus and compare tasks
	// ****************
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= {26'h0, a};
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge mclk_i);
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check($sformatf("reg %h", a), e, rd);
	endtask
	task automatic complete_run;
		if (num_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#400000;
		num_errors++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'h1;
		@(posedge mclk_i);
		rchk(6'h00, 32'h0);
		rchk(6'h08, 32'h0);
		rchk(6'h10, 32'hff);
		rchk(6'h1c, 32'h0);
		apb(1'h0, 6'h04, 32'h0);
		check("unmapped", 32'h1, {rd[30:0], err});
		apb(1'h1, 6'h10, 32'h46);
		apb(1'h1, 6'h00, 32'h41);
		apb(1'h0, 6'h1c, 32'h0);
		check("early", 32'h0, rd & 32'h20);
		repeat (64) @(posedge mclk_i);
		apb(1'h0, 6'h1c, 32'h0);
		check("started", 32'h20, rd & 32'h20);
		for (int i = 0; i < 32; i++) begin
			apb(1'h1, 6'h08, {24'h0, i[4], 2'h0, i[3:2], 1'h0, i[1:0]});
			exp = (pos_lvl[i[3:2]] > ((i[1:0] == 2'h3) ? 8'h46 : neg_lvl[i[1:0]])) ^ i[4];
			check("pin", {29'h0, exp, exp, 1'h1}, {29'h0, result_pin_o, result_event_o, result_pin_oe_o});
			check("sels", {28'h0, i[3:0]}, {28'h0, positive_input_select_o, negative_input_select_o});
		end
		for (int j = 0; j < 8; j++) begin
			apb(1'h1, 6'h00, {28'h0, j[2:0], 1'h1});
			check("hys lp", {29'h0, j[2:0]}, {29'h0, low_power_select_o, hysteresis_level_o});
		end
		apb(1'h1, 6'h08, 32'h0);
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, 6'h00, {26'h0, m[1:0], 4'h1});
			apb(1'h1, 6'h18, {31'h0, m[0]});
			apb(1'h1, 6'h1c, 32'h1);
			for (int up = 1; up >= 0; up--) begin
				pos_lvl[0] <= up[0] ? 8'hc8 : 8'h0a;
				repeat (6) @(posedge mclk_i);
				apb(1'h0, 6'h1c, 32'h0);
				exp = (m == 0) || (m == 3 && up == 1) || (m == 2 && up == 0);
				check("status", {27'h0, up[0], 3'h0, exp}, rd & 32'h11);
				check("irq", {31'h0, exp & m[0]}, {31'h0, irq_o});
				apb(1'h1, 6'h1c, 32'h0);
				apb(1'h0, 6'h1c, 32'h0);
				check("kept", {31'h0, exp}, rd & 32'h1);
				apb(1'h1, 6'h1c, 32'h1);
				@(posedge mclk_i);
				check("cleared", 32'h0, {31'h0, irq_o});
			end
		end
		for (int k = 0; k < 8; k++) begin
			apb(1'h1, 6'h00, {24'h0, k[2], 7'h41});
			sleep_mode_i <= k[1:0];
			@(posedge mclk_i);
			exp = (k[1:0] < 2'h2) || (k[1:0] == 2'h2 && k[2]);
			check("sleep", {30'h0, exp, exp}, {30'h0, analog_enable_o, result_pin_oe_o});
			rchk(6'h20, {30'h0, k[1:0]});
		end
		sleep_mode_i <= 2'h0;
		clk_en_i <= 1'h0;
		apb(1'h1, 6'h18, 32'h0);
		clk_en_i <= 1'h1;
		rchk(6'h18, 32'h1);
		complete_run();
	end
endmodule

`default_nettype wire
